// ### src/crcg_engine.sv
// CRC generator engine with register port and byte-serial folding
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module crcg_engine
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire crcg_pkg::crcg_req_s req_i,
  output logic [31:0] rdata_o,
  output logic busy_o
);
  typedef enum logic [1:0]
  {
    CRCG_IDLE = 2'b01,
    CRCG_RUN = 2'b10
  } crcg_state_e;

  crcg_state_e state_q;
  logic [5:0] mode_q;
  logic [31:0] seed_q;
  logic [31:0] sum_q;
  logic [31:0] data_q;
  logic [1:0] left_q;
  logic [31:0] rdata_q;
  logic data_wr;
  logic [7:0] cur_byte;
  logic [31:0] out_val;
  logic [31:0] in_word;
  logic [1:0] nbytes;

  // Fold one byte msb first into the running sum for the chosen polynomial
  function automatic logic [31:0] crcg_step(input logic [31:0] sum, input logic [7:0] b,
                                            input logic [1:0] poly);
    logic [31:0] s;
    logic [31:0] p;
    logic top;
    s = sum;
    p = (poly == crcg_pkg::CRCG_CRC32) ? crcg_pkg::POLY_CRC32 :
        (poly == crcg_pkg::CRCG_CRC16) ? crcg_pkg::POLY_CRC16 : crcg_pkg::POLY_CCITT;
    for (int i = 7; i >= 0; i--)
    begin
      top = (poly == crcg_pkg::CRCG_CRC32) ? s[31] : s[15];
      top = top ^ b[i];
      s = {s[30:0], 1'b0};
      if (top)
      begin
        s = s ^ p;
      end
    end
    if (poly != crcg_pkg::CRCG_CRC32)
    begin
      s = {16'h0000, s[15:0]};
    end
    return s;
  endfunction : crcg_step

  // Mirror all bits within each byte
  function automatic logic [31:0] crcg_rev_bytes(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 32; i++)
    begin
      r[(i / 8) * 8 + 7 - (i % 8)] = v[i];
    end
    return r;
  endfunction : crcg_rev_bytes

  // Mirror a checksum across its own width
  function automatic logic [31:0] crcg_rev_sum(input logic [31:0] v, input logic wide);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 32; i++)
    begin
      r[31 - i] = v[i];
    end
    if (!wide)
    begin
      r = {16'h0000, r[31:16]};
    end
    return r;
  endfunction : crcg_rev_sum

  assign data_wr = req_i.wr && (req_i.addr == crcg_pkg::ADDR_DATA);
  assign busy_o = (state_q == CRCG_RUN);
  assign cur_byte = data_q[31:24];

  // Input options: reverse bits per byte, then complement, before folding
  always_comb
  begin
    in_word = req_i.wdata;
    if (mode_q[crcg_pkg::MODE_IN_REV])
    begin
      in_word = crcg_rev_bytes(in_word);
    end
    if (mode_q[crcg_pkg::MODE_IN_CMP])
    begin
      in_word = ~in_word;
    end
    unique case (req_i.width)
      crcg_pkg::CRCG_W8: in_word = {in_word[7:0], 24'h000000};
      crcg_pkg::CRCG_W16: in_word = {in_word[15:0], 16'h0000};
      default: in_word = in_word;
    endcase
    nbytes = (req_i.width == crcg_pkg::CRCG_W32) ? 2'h3 :
             (req_i.width == crcg_pkg::CRCG_W16) ? 2'h1 : 2'h0;
  end

  // Output options applied on the read path only
  always_comb
  begin
    out_val = sum_q;
    if (mode_q[crcg_pkg::MODE_OUT_REV])
    begin
      out_val = crcg_rev_sum(out_val, mode_q[1:0] == crcg_pkg::CRCG_CRC32);
    end
    if (mode_q[crcg_pkg::MODE_OUT_CMP])
    begin
      out_val = ~out_val;
      if (mode_q[1:0] != crcg_pkg::CRCG_CRC32)
      begin
        out_val = {16'h0000, out_val[15:0]};
      end
    end
  end

  // Mode register steers polynomial and options
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_q <= crcg_pkg::MODE_RESET;
    end
    else if (req_i.wr && req_i.addr == crcg_pkg::ADDR_MODE)
    begin
      mode_q <= req_i.wdata[5:0];
    end
  end

  // Seed register keeps the last written seed for read back
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      seed_q <= crcg_pkg::SEED_RESET;
    end
    else if (req_i.wr && req_i.addr == crcg_pkg::ADDR_SEED)
    begin
      seed_q <= req_i.wdata;
    end
  end

  // Byte-serial folding; first byte folds in the write cycle itself
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= CRCG_IDLE;
      sum_q <= crcg_pkg::SEED_RESET;
      data_q <= 32'h00000000;
      left_q <= 2'h0;
    end
    else if (req_i.wr && req_i.addr == crcg_pkg::ADDR_SEED)
    begin
      sum_q <= req_i.wdata;
      state_q <= CRCG_IDLE;
      left_q <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        CRCG_IDLE:
        begin
          if (data_wr)
          begin
            sum_q <= crcg_step(sum_q, in_word[31:24], mode_q[1:0]);
            data_q <= {in_word[23:0], 8'h00};
            left_q <= nbytes;
            if (nbytes != 2'h0)
            begin
              state_q <= CRCG_RUN;
            end
          end
        end
        CRCG_RUN:
        begin
          // Data writes during this state are dropped; busy_o only flags it
          sum_q <= crcg_step(sum_q, cur_byte, mode_q[1:0]);
          data_q <= {data_q[23:0], 8'h00};
          left_q <= left_q - 2'h1;
          if (left_q == 2'h1)
          begin
            state_q <= CRCG_IDLE;
          end
        end
        default: state_q <= CRCG_IDLE;
      endcase
    end
  end

  // Read data one cycle after strobe; reading never alters the sum
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (req_i.rd)
    begin
      unique case (req_i.addr)
        crcg_pkg::ADDR_MODE: rdata_q <= {26'h0000000, mode_q};
        crcg_pkg::ADDR_SEED: rdata_q <= seed_q;
        crcg_pkg::ADDR_SUM: rdata_q <= out_val;
        default: rdata_q <= 32'h00000000;
      endcase
    end
    else
    begin
      rdata_q <= 32'h00000000;
    end
  end
  // Registered read port keeps the data output glitch free
  assign rdata_o = rdata_q;

  // Assertions
  // Word tail: three more byte steps, then free for the next write
  sequence s_word_tail;
    busy_o [*3] ##1 !busy_o;
  endsequence
  // Halfword tail: one more byte step
  sequence s_half_tail;
    busy_o ##1 !busy_o;
  endsequence
  property p_stall;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (data_wr && !busy_o && req_i.width == crcg_pkg::CRCG_W32) |=> s_word_tail;
  endproperty
  a_stall: assert property (p_stall) else $error("word write not four cycles");
  property p_half;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (data_wr && !busy_o && req_i.width == crcg_pkg::CRCG_W16) |=> s_half_tail;
  endproperty
  a_half: assert property (p_half) else $error("halfword write not two cycles");
  property p_byte;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (data_wr && !busy_o && req_i.width == crcg_pkg::CRCG_W8) |=> !busy_o;
  endproperty
  a_byte: assert property (p_byte) else $error("byte write not one cycle");
  property p_seed;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == crcg_pkg::ADDR_SEED) |=> (sum_q == $past(req_i.wdata));
  endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded");
  property p_read;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.rd && req_i.addr == crcg_pkg::ADDR_SUM) |=> (rdata_o == $past(out_val));
  endproperty
  a_read: assert property (p_read) else $error("checksum read wrong");
  property p_rdstable;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.rd && !req_i.wr && !busy_o) |=> $stable(sum_q);
  endproperty
  a_rdstable: assert property (p_rdstable) else $error("read changed sum");
  property p_cmp;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (mode_q[crcg_pkg::MODE_OUT_CMP] && !mode_q[crcg_pkg::MODE_OUT_REV] &&
       mode_q[1:0] == crcg_pkg::CRCG_CRC32) |-> (out_val == ~sum_q);
  endproperty
  a_cmp: assert property (p_cmp) else $error("output complement wrong");
  property p_narrow;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (mode_q[1:0] != crcg_pkg::CRCG_CRC32 && data_wr) |=> (sum_q[31:16] == 16'h0000);
  endproperty
  a_narrow: assert property (p_narrow) else $error("16-bit sum overflow");
  property p_hold;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (busy_o && left_q == 2'h1 && !req_i.wr) |=> !busy_o;
  endproperty
  a_hold: assert property (p_hold) else $error("busy did not end");
  // Read data stands one cycle only, then falls back to zero
  property p_rdzero;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !req_i.rd |=> (rdata_o == 32'h00000000);
  endproperty
  a_rdzero: assert property (p_rdzero) else $error("read data not cleared");
  // Mode read returns the stored bits with the upper bits clear
  property p_mode_rd;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.rd && req_i.addr == crcg_pkg::ADDR_MODE) |=>
        (rdata_o == {26'h0000000, $past(mode_q)});
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read wrong");
  // A seed write drops any pending byte steps at once
  property p_seed_abort;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == crcg_pkg::ADDR_SEED) |=> !busy_o;
  endproperty
  a_seed_abort: assert property (p_seed_abort) else $error("seed write left busy");
  // Steps count down once a cycle; a refused data write never restarts them
  property p_count;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (busy_o && left_q != 2'h1 && !(req_i.wr && req_i.addr == crcg_pkg::ADDR_SEED))
        |=> (busy_o && left_q == $past(left_q) - 2'h1);
  endproperty
  a_count: assert property (p_count) else $error("byte steps restarted");
endmodule : crcg_engine

// ### src/crcg_pkg.sv
// Package with register map, field layout and types of the CRC generator
// Functional notes
// - Polynomial selectable among CCITT, CRC-16 and CRC-32.
// - Input data may be bit-reversed and ones-complemented, independently.
// - Result may be bit-reversed and ones-complemented before reading, independently.
// - Software loads a seed that restarts the checksum register.
// - Byte data writes may arrive back to back without handshaking; a data write while busy_o is high is dropped.
// - Data writes of byte, halfword or word width processed per width.
// - Byte write folds in one clock cycle.
// - Halfword write folds as two byte steps over two cycles.
// - Word write folds as four byte steps over four cycles.
package crcg_pkg;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_SEED = 4'h4;
  localparam logic [3:0] ADDR_SUM = 4'h8;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  localparam int MODE_POLY_LSB = 0;
  localparam int MODE_IN_REV = 2;
  localparam int MODE_IN_CMP = 3;
  localparam int MODE_OUT_REV = 4;
  localparam int MODE_OUT_CMP = 5;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [31:0] SEED_RESET = 32'h0000ffff;
  localparam logic [31:0] POLY_CCITT = 32'h00001021;
  localparam logic [31:0] POLY_CRC16 = 32'h00008005;
  localparam logic [31:0] POLY_CRC32 = 32'h04c11db7;

  typedef enum logic [1:0]
  {
    CRCG_CCITT = 2'h0,
    CRCG_CRC16 = 2'h1,
    CRCG_CRC32 = 2'h2
  } crcg_poly_e;

  // Width code of a data write
  typedef enum logic [1:0]
  {
    CRCG_W8 = 2'h0,
    CRCG_W16 = 2'h1,
    CRCG_W32 = 2'h2
  } crcg_width_e;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [31:0] wdata;
    crcg_width_e width;
    logic wr;
    logic rd;
  } crcg_req_s;
endpackage : crcg_pkg

// ### tb/crcg_dma_model.sv
// Master model streaming one word as back-to-back byte writes
`timescale 1ns/1ns
module crcg_dma_model
(
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [31:0] word_i,
  input wire logic busy_i,
  output crcg_pkg::crcg_req_s req_o,
  output logic done_o
);
  int n = 4;
  crcg_pkg::crcg_req_s req_q = '0;
  assign req_o = req_q;
  assign done_o = (n == 4);
  // One byte a cycle, each gated only by busy_i; idle data toggles so stale bytes show
  always @(posedge mclk_i)
  begin
    if (go_i)
      n <= 0;
    if (n < 4 && !busy_i)
    begin
      req_q <= '{crcg_pkg::ADDR_DATA, {24'h0, word_i[31-8*n -: 8]},
                 crcg_pkg::CRCG_W8, 1'b1, 1'b0};
      n <= n + 1;
    end
    else
    begin
      req_q.wr <= 1'b0;
      req_q.wdata <= ~req_q.wdata;
    end
  end
endmodule : crcg_dma_model

// ### tb/test_crcg_engine.sv
// Self-checking bench for the CRC generator engine
`timescale 1ns/1ns
module test_crcg_engine;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  crcg_pkg::crcg_req_s req_tb = '0;
  crcg_pkg::crcg_req_s req_dma;
  logic dma_sel = 1'b0;
  logic go = 1'b0;
  logic dma_done;
  logic busy;
  logic [31:0] rdata;
  logic [31:0] dma_word = 32'h0;
  logic [31:0] sum;
  logic [5:0] md = 6'h00;
  int num_errors = 0;
  int total_checks = 0;
  crcg_engine uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .req_i(dma_sel ? req_dma : req_tb), .rdata_o(rdata), .busy_o(busy));
  crcg_dma_model dma (.mclk_i(mclk_i), .go_i(go), .word_i(dma_word), .busy_i(busy),
    .req_o(req_dma), .done_o(dma_done));
  // Free-running 100 MHz clock
  initial forever #5 mclk_i = ~mclk_i;
  // Reference fold, msb first, non-reflected
  function automatic logic [31:0] fold(logic [31:0] s, logic [7:0] b);
    logic [31:0] p;
    int wd;
    if (md[3]) b = ~b;
    if (md[2]) b = {<<{b}};
    wd = (md[1:0] == 2'h2) ? 32 : 16;
    p = md[1:0] == 2'h0 ? 32'h00001021 : md[1:0] == 2'h1 ? 32'h00008005 : 32'h04c11db7;
    s = s ^ ({24'h0, b} << (wd - 8));
    for (int i = 0; i < 8; i++)
      s = s[wd-1] ? (s << 1) ^ p : s << 1;
    return wd == 16 ? s & 32'h0000ffff : s;
  endfunction : fold
  function automatic logic [31:0] view(logic [31:0] s);
    logic [15:0] h;
    logic [31:0] r;
    h = {<<{s[15:0]}};
    r = {<<{s}};
    if (md[4]) s = md[1] ? r : {16'h0, h};
    if (md[5]) s = s ^ (md[1] ? 32'hffffffff : 32'h0000ffff);
    return s;
  endfunction : view
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] w);
    @(posedge mclk_i);
    req_tb <= '{a, d, crcg_pkg::crcg_width_e'(w), 1'b1, 1'b0};
    @(posedge mclk_i);
    req_tb.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    req_tb <= '{a, 32'h0, crcg_pkg::CRCG_W8, 1'b0, 1'b1};
    @(posedge mclk_i);
    req_tb.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic shadow(logic [31:0] d, int nb);
    for (int i = nb - 1; i >= 0; i--)
      sum = fold(sum, d[8*i +: 8]);
  endtask : shadow
  // Data write that honours busy first
  task automatic dat(logic [31:0] d, logic [1:0] w);
    int k;
    k = 0;
    #1;
    while (busy !== 1'b0 && k < 20)
    begin
      @(posedge mclk_i);
      #1 k++;
    end
    chk("busy before write", 32'h0, {31'h0, busy});
    wr(crcg_pkg::ADDR_DATA, d, w);
    shadow(d, 1 << w);
  endtask : dat
  task automatic load(logic [5:0] m, logic [31:0] s);
    md = m;
    wr(crcg_pkg::ADDR_MODE, {26'h0, m}, 2'h0);
    sum = m[1] ? s : s & 32'h0000ffff;
    wr(crcg_pkg::ADDR_SEED, sum, 2'h0);
  endtask : load
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // Hang guard, far above the nine hundred or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    logic [31:0] got;
    int k;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(crcg_pkg::ADDR_MODE, got);
    chk("mode", 32'h0, got);
    rd(crcg_pkg::ADDR_SEED, got);
    chk("seed", 32'h0000ffff, got);
    rd(crcg_pkg::ADDR_SUM, got);
    chk("sum", 32'h0000ffff, got);
    wr(4'hc, 32'hffffffff, 2'h0);
    rd(4'hc, got);
    chk("unmapped", 32'h0, got);
    rd(crcg_pkg::ADDR_MODE, got);
    chk("mode", 32'h0, got);
    // Every polynomial against every option mix, mixed widths
    for (int i = 0; i < 48; i++)
    begin
      load({i[3:0], 2'(i / 16)}, 32'h5a0f3c96 + i);
      dat(32'hc3a51e70 ^ i, 2'h2);
      dat(32'h0000b44d, 2'h1);
      dat(32'h0000007e, 2'h0);
      rd(crcg_pkg::ADDR_SUM, got);
      chk("sum", view(sum), got);
      rd(crcg_pkg::ADDR_SUM, got);
      chk("sum again", view(sum), got);
    end
    // Busy span per width; a write inside it is dropped
    for (int w = 0; w < 3; w++)
    begin
      dat(32'h12345678, 2'(w));
      k = 0;
      #1;
      while (busy === 1'b1 && k < 9)
      begin
        @(posedge mclk_i);
        #1 k++;
      end
      chk("busy cycles", (32'h1 << w) - 32'h1, 32'(k));
    end
    dat(32'h0badf00d, 2'h2);
    wr(crcg_pkg::ADDR_DATA, 32'h00000077, 2'h0);
    rd(crcg_pkg::ADDR_SUM, got);
    chk("sum after drop", view(sum), got);
    // Streamed bytes fold like one word
    load(6'h09, 32'h00001d0f);
    dma_word <= 32'h3e91c7a4;
    dma_sel <= 1'b1;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    @(posedge mclk_i);
    k = 0;
    while (dma_done !== 1'b1 && k < 20)
    begin
      @(posedge mclk_i);
      k++;
    end
    chk("stream done", 32'h1, {31'h0, dma_done});
    @(posedge mclk_i);
    dma_sel <= 1'b0;
    shadow(32'h3e91c7a4, 4);
    rd(crcg_pkg::ADDR_SUM, got);
    chk("streamed sum", view(sum), got);
    stop_test();
  end
endmodule : test_crcg_engine
